/* File: design/pss_pkg.sv */
/*
  Shared constants and types for the power-state and lock-status register block and its controller.
  Assumes a single 125 MHz clock and an active-low asynchronous reset on both ends.
*/
//
// Notes on behaviour
// R01 - bit 4 reports reset-extension select
// R02 - bits 7:5 one-hot operating state code
// R03 - reset state ignores commands, returns zero
// R04 - off state holds no register content
// R05 - latch bit 3, set 0xAA, clear 0x55
// R06 - power-on keeps latch unless battery lost
// R07 - regulator overvoltage forces latch to one
// R08 - off with wake high: restart gated by latch
// R09 - config protect set by key, exit, selftest
// R10 - config protect cleared only in diagnostic
// R11 - selftest protect set by key, exit, selftest
// R12 - clear selftest protect in active states
// R13 - control protect set by key, exit, selftest
// R14 - clear-control clears both control flags
// R15 - protected registers ignore host writes
// R16 - wrong key or state changes nothing
`default_nettype none
package pss_pkg;
  // operating state codes
  localparam logic [2:0] PSS_ST_NONE = 3'h0;
  localparam logic [2:0] PSS_ST_DIAG = 3'h1;
  localparam logic [2:0] PSS_ST_ACTIVE = 3'h2;
  localparam logic [2:0] PSS_ST_SAFE = 3'h4;
  // status register field positions
  localparam int PSS_BIT_STATE_LO = 5;
  localparam int PSS_BIT_EXT_SEL = 4;
  localparam int PSS_BIT_AUTOSTART = 3;
  localparam int PSS_BIT_CFG_PROT = 2;
  localparam int PSS_BIT_BIST_PROT = 1;
  localparam int PSS_BIT_CTRL_PROT = 0;
  // reset values of the protect flags and latch
  localparam logic PSS_RST_PROT = 1'b1;
  localparam logic PSS_RST_AUTOSTART = 1'b0;
  // keys
  localparam logic [7:0] PSS_KEY_55 = 8'h55;
  localparam logic [7:0] PSS_KEY_AA = 8'hAA;
  // command codes on the link (arbitrary encoding)
  typedef enum logic [3:0] {
    PSS_CMD_READ_STATUS = 4'h0,
    PSS_CMD_SET_AUTOSTART_DIS = 4'h1,
    PSS_CMD_CLR_AUTOSTART_DIS = 4'h2,
    PSS_CMD_SET_CFG_PROT = 4'h3,
    PSS_CMD_CLR_CFG_PROT = 4'h4,
    PSS_CMD_SET_CTRL_PROT = 4'h5,
    PSS_CMD_CLR_CTRL_PROT = 4'h6,
    PSS_CMD_WR_CFG = 4'h7,
    PSS_CMD_WR_CTRL = 4'h8,
    PSS_CMD_WR_BIST = 4'h9,
    PSS_CMD_RD_CFG = 4'hA,
    PSS_CMD_RD_CTRL = 4'hB,
    PSS_CMD_RD_BIST = 4'hC
  } pss_cmd_t;
  // controller APB register offsets
  localparam logic [11:0] PSS_OFF_CMD = 12'h000;
  localparam logic [11:0] PSS_OFF_DATA = 12'h004;
  localparam logic [11:0] PSS_OFF_STAT = 12'h008;
  localparam logic [11:0] PSS_OFF_RESP = 12'h00C;
  localparam int PSS_STAT_BUSY = 0;
endpackage : pss_pkg
`default_nettype wire

/* File: design/pss_link_if.sv */
/*
  Command link between the controller and the status device.
  Assumes both ends share sys_clk_in; one-cycle req pulse, one-cycle ack pulse.
*/
`default_nettype none
interface pss_link_if;
  import pss_pkg::*;
  logic req;
  pss_cmd_t cmd;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport ctrl (output req, output cmd, output wdata, input ack, input rdata);
  modport dev (input req, input cmd, input wdata, output ack, output rdata);
endinterface : pss_link_if
`default_nettype wire

/* File: design/pss_device.sv */
/*
  Status and lock register bank of the power device: state code, protect flags, auto-restart latch,
  and the guarded configuration, control and self-test control registers.
  Assumes the power state machine drives the state and event inputs on sys_clk_in.
*/
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none
module pss_device
  import pss_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  pss_link_if.dev link,
  input wire logic [2:0] state_code_in,
  input wire logic in_reset_state_in,
  input wire logic in_off_state_in,
  input wire logic ext_select_in,
  input wire logic battery_lost_in,
  input wire logic regulator_ov_in,
  input wire logic selftest_done_in,
  input wire logic wake_in,
  output logic restart_out,
  output logic [7:0] config_reg_out,
  output logic [7:0] control_reg_out,
  output logic [7:0] selftest_ctrl_out,
  output logic [7:0] status_out
);
  import pss_pkg::*;
  ////////////////////////////////////////////////////////////////
  logic [2:0] state_r, state_nxt;
  logic autostart_r, autostart_nxt;
  logic cfg_p_r, cfg_p_nxt;
  logic bist_p_r, bist_p_nxt;
  logic ctrl_p_r, ctrl_p_nxt;
  // three guarded registers stand in for the protected register groups
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] bst_r, bst_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic wake_q_r, wake_q_nxt;
  logic restart_r, restart_nxt;
  logic batt_seen_r, batt_seen_nxt;
  logic in_diag;
  logic in_run;
  logic left_diag;
  logic left_run;
  logic key55;
  logic keyaa;
  logic [7:0] stat;
  // status leaves through a flop so the output never glitches with the event inputs
  logic [7:0] stat_r, stat_nxt;
  ////////////////////////////////////////////////////////////////

  function automatic logic is_run(input logic [2:0] s);
    is_run = (s == PSS_ST_DIAG) || (s == PSS_ST_ACTIVE) || (s == PSS_ST_SAFE);
  endfunction : is_run

  always_comb
  begin
    in_diag = (state_code_in == PSS_ST_DIAG);
    in_run = is_run(state_code_in);
    left_diag = (state_r == PSS_ST_DIAG) && !in_diag;
    left_run = is_run(state_r) && !in_run;
    key55 = (link.wdata == PSS_KEY_55);
    keyaa = (link.wdata == PSS_KEY_AA);
    stat = '0;
    stat[PSS_BIT_STATE_LO +: 3] = state_r; // R02
    stat[PSS_BIT_EXT_SEL] = ext_select_in; // R01
    stat[PSS_BIT_AUTOSTART] = autostart_r;
    stat[PSS_BIT_CFG_PROT] = cfg_p_r;
    stat[PSS_BIT_BIST_PROT] = bist_p_r;
    stat[PSS_BIT_CTRL_PROT] = ctrl_p_r;
  end

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_code_in;
    autostart_nxt = autostart_r;
    cfg_p_nxt = cfg_p_r;
    bist_p_nxt = bist_p_r;
    ctrl_p_nxt = ctrl_p_r;
    cfg_nxt = cfg_r;
    ctl_nxt = ctl_r;
    bst_nxt = bst_r;
    ack_nxt = 1'b0;
    rd_nxt = rd_r;
    wake_q_nxt = wake_in;
    restart_nxt = 1'b0;
    batt_seen_nxt = batt_seen_r | battery_lost_in;
    stat_nxt = stat;
    if (link.req)
    begin
      ack_nxt = 1'b1;
      rd_nxt = 8'h00;
      if (!in_reset_state_in && !in_off_state_in) // R03
      begin
        // unknown command codes answer zero and change nothing
        unique case (link.cmd)
          PSS_CMD_READ_STATUS: rd_nxt = stat;
          PSS_CMD_SET_AUTOSTART_DIS: if (keyaa) autostart_nxt = 1'b1; // R05 R16
          PSS_CMD_CLR_AUTOSTART_DIS: if (key55) autostart_nxt = 1'b0; // R05 R16
          PSS_CMD_SET_CFG_PROT: if (key55 && in_diag) cfg_p_nxt = 1'b1; // R09 R16
          PSS_CMD_CLR_CFG_PROT: if (keyaa && in_diag) cfg_p_nxt = 1'b0; // R10 R16
          PSS_CMD_SET_CTRL_PROT:
            if (key55 && in_run)
            begin
              bist_p_nxt = 1'b1; // R11
              ctrl_p_nxt = 1'b1; // R13
            end
          PSS_CMD_CLR_CTRL_PROT:
            if (keyaa && in_run)
            begin
              bist_p_nxt = 1'b0; // R12
              ctrl_p_nxt = 1'b0; // R14
            end
          PSS_CMD_WR_CFG: if (!cfg_p_r) cfg_nxt = link.wdata; // R15
          PSS_CMD_WR_CTRL: if (!ctrl_p_r) ctl_nxt = link.wdata; // R15
          PSS_CMD_WR_BIST: if (!bist_p_r) bst_nxt = link.wdata; // R15
          PSS_CMD_RD_CFG: rd_nxt = cfg_r;
          PSS_CMD_RD_CTRL: rd_nxt = ctl_r;
          PSS_CMD_RD_BIST: rd_nxt = bst_r;
          default: rd_nxt = 8'h00;
        endcase
      end
    end
    // hardware sets win over a command clear in the same cycle
    if (left_diag || selftest_done_in)
    begin
      cfg_p_nxt = 1'b1; // R09
      ctrl_p_nxt = 1'b1; // R13
    end
    if (left_run || selftest_done_in)
      bist_p_nxt = 1'b1; // R11
    if (regulator_ov_in)
      autostart_nxt = 1'b1; // R07
    if (in_off_state_in)
    begin
      // digital core is dark: registers back to power-on values
      state_nxt = PSS_ST_NONE; // R04
      cfg_p_nxt = PSS_RST_PROT;
      bist_p_nxt = PSS_RST_PROT;
      ctrl_p_nxt = PSS_RST_PROT;
      cfg_nxt = 8'h00;
      ctl_nxt = 8'h00;
      bst_nxt = 8'h00;
      rd_nxt = 8'h00;
      // latch survives, except after battery loss on all supplies
      if (batt_seen_r)
        autostart_nxt = PSS_RST_AUTOSTART; // R06
      batt_seen_nxt = 1'b0;
      if (wake_in && (!autostart_r || !wake_q_r)) // R08
        restart_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= PSS_ST_NONE;
      autostart_r <= PSS_RST_AUTOSTART;
      cfg_p_r <= PSS_RST_PROT;
      bist_p_r <= PSS_RST_PROT;
      ctrl_p_r <= PSS_RST_PROT;
      cfg_r <= 8'h00;
      ctl_r <= 8'h00;
      bst_r <= 8'h00;
      ack_r <= 1'b0;
      rd_r <= 8'h00;
      // low like an idle wake pin; a wake held high through reset reads as a rising edge
      wake_q_r <= 1'b0;
      restart_r <= 1'b0;
      batt_seen_r <= 1'b0;
      // flags and latch at power-on values; ext select is not known yet
      stat_r <= {3'h0, 1'h0, PSS_RST_AUTOSTART, PSS_RST_PROT, PSS_RST_PROT, PSS_RST_PROT};
    end
    else
    begin
      state_r <= state_nxt;
      autostart_r <= autostart_nxt;
      cfg_p_r <= cfg_p_nxt;
      bist_p_r <= bist_p_nxt;
      ctrl_p_r <= ctrl_p_nxt;
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      bst_r <= bst_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      wake_q_r <= wake_q_nxt;
      restart_r <= restart_nxt;
      batt_seen_r <= batt_seen_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rd_r;
  assign restart_out = restart_r;
  assign config_reg_out = cfg_r;
  assign control_reg_out = ctl_r;
  assign selftest_ctrl_out = bst_r;
  assign status_out = stat_r;
endmodule : pss_device
`default_nettype wire

/* File: design/pss_ctrl.sv */
/*
  Host-side controller: each APB write of the command register while idle turns into one link command; writes while busy are dropped.
  Assumes software polls the busy bit before issuing a new command.
*/
`default_nettype none
module pss_ctrl
  import pss_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pss_link_if.ctrl link
);
  import pss_pkg::*;
  typedef enum logic [0:0] {PSS_IDLE = 1'b0, PSS_WAIT = 1'b1} pss_cst_t;
  pss_cst_t st_r, st_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [7:0] data_r, data_nxt, resp_r, resp_nxt;
  logic req_r, req_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic wr, rd;

  always_comb
  begin
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    resp_nxt = resp_r;
    req_nxt = 1'b0;
    prd_nxt = prd_r;
    if (rd)
    begin
      unique case (paddr)
        PSS_OFF_CMD: prd_nxt = {28'h0, cmd_r};
        PSS_OFF_DATA: prd_nxt = {24'h0, data_r};
        PSS_OFF_STAT: prd_nxt = {31'h0, st_r == PSS_WAIT};
        PSS_OFF_RESP: prd_nxt = {24'h0, resp_r};
        default: prd_nxt = 32'h0;
      endcase
    end
    if (wr && paddr == PSS_OFF_DATA)
      data_nxt = pwdata[7:0];
    unique case (st_r)
      PSS_IDLE:
        if (wr && paddr == PSS_OFF_CMD)
        begin
          // writing the command register launches it
          cmd_nxt = pwdata[3:0];
          req_nxt = 1'b1;
          st_nxt = PSS_WAIT;
        end
      PSS_WAIT:
        if (link.ack)
        begin
          resp_nxt = link.rdata;
          st_nxt = PSS_IDLE;
        end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= PSS_IDLE;
      cmd_r <= 4'h0;
      data_r <= 8'h00;
      resp_r <= 8'h00;
      req_r <= 1'b0;
      prd_r <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      resp_r <= resp_nxt;
      req_r <= req_nxt;
      prd_r <= prd_nxt;
    end
  end

  assign prdata = prd_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.req = req_r;
  assign link.cmd = pss_cmd_t'(cmd_r); // R05 R10 R12 R14
  assign link.wdata = data_r;
endmodule : pss_ctrl
`default_nettype wire

/* File: sim/pss_link_properties.sv */
/*
  checker: concurrent assertions on the command link.
  assumes the bench instantiates it beside pss_link_if.
*/
`default_nettype none
module pss_link_properties
  import pss_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic req,
  input wire pss_cmd_t cmd,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  //////////////////////////////
  sequence s_req;
    req;
  endsequence
  sequence s_ans;
    ack ##1 !ack;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ans)
    else $error("no ack one cycle after req");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without req");
  a_req_single: assert property (req |=> !req)
    else $error("req longer than one cycle");
  a_one_outstanding: assert property (ack |-> !req)
    else $error("req while ack");
  a_quiet_gap: assert property (ack |=> !req [*2])
    else $error("req too soon after ack");
  a_rdata_holds: assert property (!ack |-> $stable(rdata))
    else $error("rdata moved without ack");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  // a wider state code would mean two states at once
  a_state_onehot: assert property (ack && $past(cmd) == PSS_CMD_READ_STATUS |-> $onehot0(rdata[7:5]))
    else $error("state code not one-hot");
  c_handshake: cover property (s_req ##1 ack);
endmodule : pss_link_properties
`default_nettype wire

/* File: sim/pmic_state_and_lock_status_test.sv */
/*
  bench: controller and status device joined by the link, driven over apb.
  assumes the design files are compiled first.
*/
`default_nettype none
module pmic_state_and_lock_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pss_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, restart;
  logic rst_st, off_st, ext, bat, ov, st_done, wake;
  logic [2:0] st;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] cfg_q, ctl_q, bist_q, stat_q, rsp;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  pss_link_if link();
  pss_device pss_device_i (.sys_clk_in(clk), .reset_n_in(rst_n), .link(link.dev), .state_code_in(st),
    .in_reset_state_in(rst_st), .in_off_state_in(off_st), .ext_select_in(ext), .battery_lost_in(bat),
    .regulator_ov_in(ov), .selftest_done_in(st_done), .wake_in(wake), .restart_out(restart),
    .config_reg_out(cfg_q), .control_reg_out(ctl_q), .selftest_ctrl_out(bist_q), .status_out(stat_q));
  pss_ctrl pss_ctrl_i (.sys_clk_in(clk), .reset_n_in(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.ctrl));
  pss_link_properties pss_link_properties_i (.sys_clk_in(clk), .reset_n_in(rst_n), .req(link.req),
    .cmd(link.cmd), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  //////////////////////////////
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // about 40 commands of 15 cycles each
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // busy stuck or unknown falls to the cycle ceiling
  task cmd(input pss_cmd_t c, input logic [7:0] d);
    apb(1, PSS_OFF_DATA, {24'h0, d});
    apb(1, PSS_OFF_CMD, {28'h0, c});
    do apb(0, PSS_OFF_STAT, 0); while (rdat[PSS_STAT_BUSY] !== 1'b0);
    apb(0, PSS_OFF_RESP, 0);
    rsp = rdat[7:0];
  endtask : cmd
  task stat(input logic [7:0] e);
    cmd(PSS_CMD_READ_STATUS, 8'h00);
    chk(rsp, e);
    chk(stat_q, e);
  endtask : stat
  //////////////////////////////
  initial
  begin
    rst_n = 0;
    {psel, penable, pwrite, paddr, pwdata, st} = '0;
    {rst_st, off_st, ext, bat, ov, st_done, wake} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    stat(8'h07);
    for (int i = 0; i < 3; i++)
    begin
      st <= 3'h1 << i;
      stat({3'h1 << i, 5'h07});
    end
    ext <= 1;
    stat(8'h97);
    cmd(PSS_CMD_SET_AUTOSTART_DIS, 8'h55);
    stat(8'h97);
    cmd(PSS_CMD_SET_AUTOSTART_DIS, 8'hAA);
    stat(8'h9F);
    cmd(PSS_CMD_CLR_AUTOSTART_DIS, 8'h55);
    stat(8'h97);
    ov <= 1;
    @(posedge clk);
    ov <= 0;
    stat(8'h9F);
    cmd(PSS_CMD_CLR_AUTOSTART_DIS, 8'h55);
    cmd(PSS_CMD_CLR_CFG_PROT, 8'hAA);
    stat(8'h97);
    st <= PSS_ST_DIAG;
    cmd(PSS_CMD_CLR_CFG_PROT, 8'hAA);
    stat(8'h33);
    cmd(PSS_CMD_WR_CFG, 8'h5A);
    chk(cfg_q, 8'h5A);
    cmd(PSS_CMD_SET_CFG_PROT, 8'h55);
    stat(8'h37);
    cmd(PSS_CMD_WR_CFG, 8'h33);
    chk(cfg_q, 8'h5A);
    cmd(PSS_CMD_RD_CFG, 8'h00);
    chk(rsp, 8'h5A);
    cmd(PSS_CMD_CLR_CFG_PROT, 8'hAA);
    st <= PSS_ST_ACTIVE;
    stat(8'h57);
    cmd(PSS_CMD_CLR_CTRL_PROT, 8'h55);
    stat(8'h57);
    cmd(PSS_CMD_CLR_CTRL_PROT, 8'hAA);
    stat(8'h54);
    cmd(PSS_CMD_WR_CTRL, 8'h3C);
    chk(ctl_q, 8'h3C);
    cmd(PSS_CMD_WR_BIST, 8'hC3);
    chk(bist_q, 8'hC3);
    cmd(PSS_CMD_SET_CTRL_PROT, 8'h55);
    stat(8'h57);
    cmd(PSS_CMD_WR_CTRL, 8'h00);
    chk(ctl_q, 8'h3C);
    cmd(PSS_CMD_RD_CTRL, 8'h00);
    chk(rsp, 8'h3C);
    cmd(PSS_CMD_CLR_CTRL_PROT, 8'hAA);
    st_done <= 1;
    @(posedge clk);
    st_done <= 0;
    stat(8'h57);
    rst_st <= 1;
    cmd(PSS_CMD_CLR_CTRL_PROT, 8'hAA);
    chk(rsp, 8'h00);
    rst_st <= 0;
    stat(8'h57);
    cmd(PSS_CMD_RD_BIST, 8'h00);
    chk(rsp, 8'hC3);
    // a write answers zero, so the off state clears nothing the link still shows
    cmd(PSS_CMD_WR_BIST, 8'h11);
    chk(bist_q, 8'hC3);
    wake <= 1;
    off_st <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({7'h0, restart}, 8'h01);
    chk(ctl_q, 8'h00);
    @(posedge clk);
    off_st <= 0;
    wake <= 0;
    ov <= 1;
    @(posedge clk);
    ov <= 0;
    off_st <= 1;
    repeat (2) @(posedge clk);
    wake <= 1;
    @(negedge clk);
    chk({7'h0, restart}, 8'h00);
    @(posedge clk);
    @(negedge clk);
    chk({7'h0, restart}, 8'h01);
    @(posedge clk);
    @(negedge clk);
    chk({7'h0, restart}, 8'h00);
    @(posedge clk);
    off_st <= 0;
    stat(8'h5F);
    cmd(PSS_CMD_WR_BIST, 8'h11);
    chk(bist_q, 8'h00);
    bat <= 1;
    @(posedge clk);
    bat <= 0;
    off_st <= 1;
    @(posedge clk);
    off_st <= 0;
    stat(8'h57);
    stop_test();
  end
endmodule : pmic_state_and_lock_status_test
`default_nettype wire
